// ### core/emb_pkg.sv
/*
   emb_pkg: shared constants, types and packed carriers for the external memory
   bus control block. Assumes a single 250 MHz clock and a synchronous reset.
*/
package emb_pkg;
   // oscillator periods per sequencer slot
   localparam int unsigned STROBE_PERIOD_OSC = 3;
   localparam logic [1:0]  PHASE_LAST        = 2'(STROBE_PERIOD_OSC - 1);
   localparam logic [1:0]  PHASE_RESET       = 2'h0;
   localparam logic [7:0]  BYTE_RESET        = 8'h00;
   localparam logic [15:0] ADDR_RESET        = 16'h0000;
   localparam logic        FETCH_SEL_RESET   = 1'b0;

   // kind of bus cycle requested by the core
   typedef enum logic [2:0] {
      EMB_CYC_IDLE,
      EMB_CYC_CODE,
      EMB_CYC_CODE_INT,
      EMB_CYC_XRD_WIDE,
      EMB_CYC_XWR_WIDE,
      EMB_CYC_XRD_IDX,
      EMB_CYC_XWR_IDX
   } emb_cyc_t;

   // request from the core
   typedef struct packed {
      emb_cyc_t    kind;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } emb_req_t;

   // strobe set produced by the sequencer
   typedef struct packed {
      logic ale;
      logic prog_store;
      logic rd;
      logic wr;
      logic addr_phase;
   } emb_strb_t;

   // true for external data move cycles
   function automatic logic emb_is_xdata(input emb_cyc_t k);
      return (k == EMB_CYC_XRD_WIDE) || (k == EMB_CYC_XWR_WIDE) ||
             (k == EMB_CYC_XRD_IDX) || (k == EMB_CYC_XWR_IDX);
   endfunction

   // true for external data move reads
   function automatic logic emb_is_xread(input emb_cyc_t k);
      return (k == EMB_CYC_XRD_WIDE) || (k == EMB_CYC_XRD_IDX);
   endfunction
endpackage

// ### core/emb_sync.sv
/*
   emb_sync: two flip-flop synchroniser for pin inputs.
   Assumes the input is asynchronous to clk; only the second stage is read.
*/
`timescale 1ns/1ps
module emb_sync
   import emb_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // pin and synchronised level
   input  wire logic pin,
   output logic      level
);
   logic meta;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta  <= 1'b0;
         level <= 1'b0;
      end else begin
         meta  <= pin;
         level <= meta;
      end
   end
endmodule

// ### core/emb_phase.sv
/*
   emb_phase: divides the oscillator clock by three into a one-cycle pulse.
   Assumes clk is the oscillator clock.
*/
`timescale 1ns/1ps
module emb_phase
   import emb_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // phase outputs
   output logic [1:0]      phase,
   output logic            tick
);
   // tick marks the last phase of each three-period slot
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase <= PHASE_RESET;
         tick  <= 1'b0;
      end else begin
         phase <= (phase == PHASE_LAST) ? PHASE_RESET : phase + 2'h1;
         tick  <= (phase == PHASE_LAST - 2'h1);
      end
   end
endmodule

// ### core/emb_ctrl.sv
/*
   emb_ctrl: external memory bus control. Drives the high address byte, the
   multiplexed address/data lines, program-store / flash-read strobe, the
   address-latch strobe, latches the external-fetch select at reset end and
   gates external flash programming.
   Assumes the core holds req stable from req_valid until req_done, and that
   clk is the oscillator clock; pins are synchronised here.
   Read data passes the same two-stage synchroniser as the other pins, so
   req_done and rdata trail the end of the data slot by one period; the core
   sees a slightly longer access in exchange for a clean capture.
*/
`timescale 1ns/1ps
// Summary of operation
// RL1: wide pointer and fetch drive upper address
// RL2: indexed access drives port latch on high
// RL3: program strobe each third period on fetch; here one two-period pulse per code fetch outside programming mode
// RL4: program strobe idle during data moves
// RL5: program strobe idle for internal execution
// RL6: programming mode: strobe flags data reads
// RL7: address latch each third period, except moves; here one pulse per code fetch only
// RL8: fetch select latched at end of reset
// RL9: low select fetches all code externally; here it only sets fetch_external
// RL10: low enable pin blocks flash programming
// RL11: programming needs pin high and bit set
// RL12: low address and data share eight lines
// RL13: high address stable through whole access
module emb_ctrl
   import emb_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // core request
   input  wire logic        req_valid,
   input  wire emb_req_t    req,
   output logic             req_done,
   output logic [7:0]       rdata,
   // configuration
   input  wire logic [7:0]  high_address_port_latch,
   input  wire logic        flash_program_enable_bit,
   input  wire logic        ext_prog_mode,
   // pins
   input  wire logic        external_fetch_select,
   input  wire logic        flash_program_enable_pin,
   output logic [7:0]       high_address_lines,
   input  wire logic [7:0]  muxed_addr_data_in,
   output logic [7:0]       muxed_addr_data_out,
   output logic             muxed_addr_data_oe,
   output logic             program_store_strobe_n,
   output logic             flash_read_strobe_n,
   output logic             addr_latch_strobe,
   output logic             rd_strobe_n,
   output logic             wr_strobe_n,
   // status
   output logic             fetch_external,
   output logic             flash_prog_allowed
);
   typedef enum logic [1:0] {EMB_ST_IDLE, EMB_ST_ADDR, EMB_ST_DATA} emb_state_t;

   logic [1:0]  phase;
   logic        tick;
   logic        sel_sync;
   logic        pen_sync;
   logic        rst_seen;
   logic        fetch_sel;
   emb_state_t  state;
   emb_req_t    cur;
   logic [7:0]  next_high;
   logic [7:0]  bus_in;
   logic [7:0]  bus_meta;
   emb_strb_t   strb;
   logic        take;
   logic        take_int;
   logic        cap_pend;

   // slot timing, counted in clock periods after the take edge t:
   //   t+1 .. t+3  address slot, low address on the shared lines, ale at t+1
   //   t+4 .. t+5  data slot, code, read or write strobe low for two periods
   //               writes put wdata on the shared lines over the same periods
   //   t+6         strobes released, sequencer back to idle
   //   t+7         byte taken from the second sync stage, req_done pulses
   // the next take can come no earlier than the tick at t+9

   // slot divider: tick marks the last period of each three-period slot
   emb_phase u_phase (
      .clk   (clk),
      .rst_n (rst_n),
      .phase (phase),
      .tick  (tick)
   );

   // both control pins come from the board, two stages each
   emb_sync u_sel (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (external_fetch_select),
      .level (sel_sync)
   );

   emb_sync u_pen (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (flash_program_enable_pin),
      .level (pen_sync)
   );

   // data bus is a pin too: two stages before capture
   // the capture waits for the second stage, see the slot timing above
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_meta <= BYTE_RESET;
         bus_in   <= BYTE_RESET;
      end else begin
         bus_meta <= muxed_addr_data_in;
         bus_in   <= bus_meta;
      end
   end

   // catch the select on the first cycles after reset release; sync delay is
   // covered by waiting one full slot before committing
   // the latched value is never sampled again, so a select pin that moves
   // later has no effect until the next reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rst_seen  <= 1'b0;
         fetch_sel <= FETCH_SEL_RESET;
      end else if (!rst_seen && tick) begin
         rst_seen  <= 1'b1;
         fetch_sel <= sel_sync;                                // [RL8]
      end
   end

   // low latched select sets fetch_external, a status flag only; internal fetch requests still run without a bus cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fetch_external <= 1'b1;
      end else begin
         fetch_external <= !fetch_sel;                         // [RL9]
      end
   end

   // flash programming gate: pin high and software bit both needed
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flash_prog_allowed <= 1'b0;
      end else begin
         flash_prog_allowed <= pen_sync && flash_program_enable_bit; // [RL10] [RL11]
      end
   end

   // high byte source depends on the access type
   // indexed moves carry no high address of their own, so the port latch
   // contents go out instead
   always_comb begin
      next_high = high_address_lines;
      if (state == EMB_ST_IDLE && req_valid && rst_seen) begin
         case (req.kind)
            EMB_CYC_CODE, EMB_CYC_XRD_WIDE, EMB_CYC_XWR_WIDE: next_high = req.addr[15:8]; // [RL1]
            EMB_CYC_XRD_IDX, EMB_CYC_XWR_IDX: next_high = high_address_port_latch;       // [RL2]
            default: next_high = high_address_lines;
         endcase
      end
   end

   // a request is taken only on a slot boundary, once the select is latched,
   // and never in the cycle that reports the previous one as done
   assign take     = (state == EMB_ST_IDLE) && req_valid && rst_seen && tick && !req_done;
   assign take_int = take && (req.kind == EMB_CYC_CODE_INT || req.kind == EMB_CYC_IDLE); // internal: no bus cycle [RL5]

   // sequencer: one three-period slot for address, one for data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= EMB_ST_IDLE;
         cur   <= '0;
      end else begin
         case (state)
            EMB_ST_IDLE: begin
               if (take) begin
                  cur <= req;
                  if (!take_int) begin
                     state <= EMB_ST_ADDR;
                  end
               end
            end
            EMB_ST_ADDR: begin
               if (tick) begin
                  state <= EMB_ST_DATA;
               end
            end
            EMB_ST_DATA: begin
               if (tick) begin
                  state <= EMB_ST_IDLE;
               end
            end
            default: state <= EMB_ST_IDLE;
         endcase
      end
   end

   // strobes are registered, so the byte is on the pins from t+4 and leaves
   // the second sync stage at t+6; taking bus_in at t+6 would catch the address
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cap_pend <= 1'b0;
         req_done <= 1'b0;
         rdata    <= BYTE_RESET;
      end else begin
         cap_pend <= (state == EMB_ST_DATA) && tick;
         req_done <= cap_pend || take_int;
         if (cap_pend) begin
            rdata <= bus_in;
         end
      end
   end

   // held from address slot to end of data slot
   // an internal request leaves the lines at the last external address
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         high_address_lines <= BYTE_RESET;
      end else if (state == EMB_ST_IDLE && tick) begin
         high_address_lines <= next_high;                      // [RL13]
      end
   end

   // strobe decode from state and phase
   always_comb begin
      strb = '0;
      strb.addr_phase = (state == EMB_ST_ADDR);
      case (state)
         EMB_ST_ADDR: begin
            // ale pulses one period in the address slot, skipped on data moves
            strb.ale = (phase == PHASE_RESET) && !emb_is_xdata(cur.kind); // [RL7]
         end
         EMB_ST_DATA: begin
            strb.prog_store = (cur.kind == EMB_CYC_CODE) && (phase != PHASE_LAST); // [RL3] [RL4]
            strb.rd = emb_is_xread(cur.kind) && (phase != PHASE_LAST);
            strb.wr = (cur.kind == EMB_CYC_XWR_WIDE || cur.kind == EMB_CYC_XWR_IDX) &&
                      (phase != PHASE_LAST);
         end
         default: strb = '0;
      endcase
   end

   // address-latch pin, the only active-high strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addr_latch_strobe <= 1'b0;
      end else begin
         addr_latch_strobe <= strb.ale;                        // [RL7]
      end
   end

   // program-store pin; in programming mode the same pin reports data reads,
   // and the flash-read pin mirrors it there
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         program_store_strobe_n <= 1'b1;
         flash_read_strobe_n    <= 1'b1;
      end else begin
         program_store_strobe_n <= ext_prog_mode ? !strb.rd : !strb.prog_store; // [RL3] [RL6]
         flash_read_strobe_n    <= !(ext_prog_mode && strb.rd);           // [RL6]
      end
   end

   // plain read strobe, silent in programming mode where the flash-read pin
   // takes over
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_strobe_n <= 1'b1;
      end else begin
         rd_strobe_n <= !(strb.rd && !ext_prog_mode);
      end
   end

   // write strobe; in programming mode a write reaches the flash only while
   // the gate is open, otherwise the cycle runs with the strobe held off
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_strobe_n <= 1'b1;
      end else begin
         wr_strobe_n <= !(strb.wr && (ext_prog_mode ? flash_prog_allowed : 1'b1)); // [RL10] [RL11]
      end
   end

   // low address in address slot, write data in data slot on shared lines
   // the lines are released otherwise so the memory can answer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         muxed_addr_data_out <= BYTE_RESET;
         muxed_addr_data_oe  <= 1'b0;
      end else if (strb.addr_phase) begin
         muxed_addr_data_out <= cur.addr[7:0];                 // [RL12]
         muxed_addr_data_oe  <= 1'b1;
      end else if (state == EMB_ST_DATA && strb.wr) begin
         muxed_addr_data_out <= cur.wdata;                     // [RL12]
         muxed_addr_data_oe  <= 1'b1;
      end else begin
         muxed_addr_data_oe  <= 1'b0;
      end
   end
endmodule

// ### sim/emb_ctrl_props.sv
/*
   emb_ctrl_props: port-level checker for emb_ctrl.
   Assumes the bench holds req steady from req_valid until req_done.
*/
`timescale 1ns/1ps
module emb_ctrl_props
   import emb_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // core side
   input wire logic       req_valid,
   input wire emb_req_t   req,
   input wire logic [7:0] high_address_port_latch,
   input wire logic       ext_prog_mode,
   // pins and status
   input wire logic [7:0] high_address_lines,
   input wire logic [7:0] muxed_addr_data_out,
   input wire logic       muxed_addr_data_oe,
   input wire logic       program_store_strobe_n,
   input wire logic       addr_latch_strobe,
   input wire logic       rd_strobe_n,
   input wire logic       wr_strobe_n,
   input wire logic       fetch_external,
   input wire logic       flash_prog_allowed
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic is_x;
   logic is_wide;
   logic is_idx;
   logic strb;
   // decode of the request held by the core
   assign is_idx  = req_valid && (req.kind == EMB_CYC_XRD_IDX || req.kind == EMB_CYC_XWR_IDX);
   assign is_wide = req_valid && (req.kind inside {EMB_CYC_CODE, EMB_CYC_XRD_WIDE, EMB_CYC_XWR_WIDE});
   assign is_x    = is_idx || (req_valid && (req.kind == EMB_CYC_XRD_WIDE || req.kind == EMB_CYC_XWR_WIDE));
   assign strb    = !program_store_strobe_n || !rd_strobe_n || !wr_strobe_n;

   property p_ale_gap; $rose(addr_latch_strobe) |=> !addr_latch_strobe [*2]; endproperty
   a_ale_gap: assert property (p_ale_gap)
      else $error("address latch pulses closer than three cycles");
   property p_ale_xdata; is_x |-> !addr_latch_strobe; endproperty
   a_ale_xdata: assert property (p_ale_xdata)
      else $error("address latch pulse during data move");
   property p_ps_xdata; is_x && !ext_prog_mode |-> program_store_strobe_n; endproperty
   a_ps_xdata: assert property (p_ps_xdata)
      else $error("program strobe during data move");
   property p_ps_int; req_valid && req.kind == EMB_CYC_CODE_INT |-> program_store_strobe_n; endproperty
   a_ps_int: assert property (p_ps_int)
      else $error("program strobe during internal execution");
   property p_ps_width; $fell(program_store_strobe_n) |=> !program_store_strobe_n ##1 program_store_strobe_n; endproperty
   a_ps_width: assert property (p_ps_width)
      else $error("program strobe not two cycles low");
   property p_hi_wide; is_wide && strb |-> high_address_lines == req.addr[15:8]; endproperty
   a_hi_wide: assert property (p_hi_wide)
      else $error("high lines differ from upper address");
   property p_hi_idx; is_idx && strb |-> high_address_lines == high_address_port_latch; endproperty
   a_hi_idx: assert property (p_hi_idx)
      else $error("high lines differ from port latch");
   property p_hi_stable; strb |-> $stable(high_address_lines); endproperty
   a_hi_stable: assert property (p_hi_stable)
      else $error("high lines moved during strobe");
   property p_lo_mux; req_valid && addr_latch_strobe |-> muxed_addr_data_oe && muxed_addr_data_out == req.addr[7:0];
   endproperty
   a_lo_mux: assert property (p_lo_mux)
      else $error("low address not on shared lines at latch pulse");
   property p_fetch; rst_n [*8] |=> $stable(fetch_external); endproperty
   a_fetch: assert property (p_fetch)
      else $error("fetch select changed after latching");
   property p_prog; !wr_strobe_n && ext_prog_mode |-> flash_prog_allowed; endproperty
   a_prog: assert property (p_prog)
      else $error("write strobe while programming blocked");
endmodule

// ### sim/emb_ext_mem.sv
/*
   emb_ext_mem: behavioural external memory on the shared bus.
   Assumes the controller latches a low address before each strobe.
*/
`timescale 1ns/1ps
module emb_ext_mem
   import emb_pkg::*;
(
   // clock
   input  wire logic       clk,
   // bus from the controller
   input  wire logic       program_store_strobe_n,
   input  wire logic       rd_strobe_n,
   input  wire logic [7:0] high_address_lines,
   input  wire logic [7:0] muxed_addr_data_out,
   input  wire logic       muxed_addr_data_oe,
   // data back
   output logic      [7:0] muxed_addr_data_in
);
   logic [7:0] lo;
   // latch the low byte while the controller drives the address slot
   always_ff @(posedge clk) begin
      if (muxed_addr_data_oe && program_store_strobe_n && rd_strobe_n) lo <= muxed_addr_data_out;
   end
   // content is a mix of both address bytes, known to the bench; a released
   // bus shows the inverse of the last driven byte so it never passes as data
   assign muxed_addr_data_in = muxed_addr_data_oe ? muxed_addr_data_out :
                               (!program_store_strobe_n || !rd_strobe_n) ? (high_address_lines ^ lo ^ 8'h5A) :
                               ~muxed_addr_data_out;
endmodule

// ### sim/external_memory_bus_control_tb_top.sv
/*
   external_memory_bus_control_tb_top: directed bench for emb_ctrl.
   Assumes emb_ext_mem answers reads with high ^ low ^ 5A.
*/
`timescale 1ns/1ps
module external_memory_bus_control_tb_top;
   import emb_pkg::*;
   logic clk, rst_n, req_valid, req_done, bit_en, prog_mode, sel, pin, oe, ps_n, fr_n, ale, rd_n, wr_n, fx, allow;
   logic [7:0] rdata, latch, hi, mo, mi, wbus, got;
   emb_req_t req;
   int fail_count = 0;
   int checked = 0;
   int n_ale, n_ps, n_fr, n_rd, n_wr;
   emb_ctrl dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_done(req_done), .rdata(rdata),
      .high_address_port_latch(latch), .flash_program_enable_bit(bit_en), .ext_prog_mode(prog_mode),
      .external_fetch_select(sel), .flash_program_enable_pin(pin), .high_address_lines(hi),
      .muxed_addr_data_in(mi), .muxed_addr_data_out(mo), .muxed_addr_data_oe(oe), .program_store_strobe_n(ps_n),
      .flash_read_strobe_n(fr_n), .addr_latch_strobe(ale), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n),
      .fetch_external(fx), .flash_prog_allowed(allow));
   emb_ext_mem mem (.clk(clk), .program_store_strobe_n(ps_n), .rd_strobe_n(rd_n), .high_address_lines(hi),
      .muxed_addr_data_out(mo), .muxed_addr_data_oe(oe), .muxed_addr_data_in(mi));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // count strobe pulses; the write byte is caught while the strobe is low
   always @(posedge clk) begin
      if ($rose(ale)) n_ale++;
      if ($fell(ps_n)) n_ps++;
      if ($fell(fr_n)) n_fr++;
      if ($fell(rd_n)) n_rd++;
      if ($fell(wr_n)) n_wr++;
      if (!wr_n) wbus = mo;
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one bus cycle; eale of 255 skips the latch pulse count
   task op(input emb_cyc_t k, input logic [15:0] a, input int eale, eps, erd, ewr, efr);
      int b_ale, b_ps, b_fr, b_rd, b_wr, i;
      b_ale = n_ale; b_ps = n_ps; b_fr = n_fr; b_rd = n_rd; b_wr = n_wr;
      @(posedge clk);
      req <= '{k, a, ~a[7:0]};
      req_valid <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if (req_done === 1'b1) break;
      end
      if (i == 40) chk(8'h00, 8'h01);
      got = rdata;
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      if (eale != 255) chk(8'(n_ale - b_ale), 8'(eale));
      chk(8'(n_ps - b_ps), 8'(eps));
      chk(8'(n_rd - b_rd), 8'(erd));
      chk(8'(n_wr - b_wr), 8'(ewr));
      chk(8'(n_fr - b_fr), 8'(efr));
      if (ewr != 0) chk(wbus, ~a[7:0]);
   endtask
   task complete_run;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // sequences take a few hundred cycles; far more means a hang
   initial begin
      #(4 * 20000);
      fail_count++;
      complete_run();
   end
   initial begin
      rst_n = 1'b0; req_valid = 1'b0; req = '0; latch = 8'hC3; bit_en = 1'b0; prog_mode = 1'b0;
      sel = 1'b0; pin = 1'b1; // board ties select low and enable high
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk(8'(fx), 8'h01);
      op(EMB_CYC_CODE, 16'hA51E, 1, 1, 0, 0, 0);
      chk(got, 8'hA5 ^ 8'h1E ^ 8'h5A);
      op(EMB_CYC_CODE_INT, 16'h0040, 255, 0, 0, 0, 0);
      op(EMB_CYC_IDLE, 16'h0041, 255, 0, 0, 0, 0);
      op(EMB_CYC_XRD_WIDE, 16'h7E81, 0, 0, 1, 0, 0);
      chk(got, 8'h7E ^ 8'h81 ^ 8'h5A);
      op(EMB_CYC_XWR_WIDE, 16'h1234, 0, 0, 0, 1, 0);
      op(EMB_CYC_XRD_IDX, 16'h99F0, 0, 0, 1, 0, 0);
      chk(got, 8'hC3 ^ 8'hF0 ^ 8'h5A);
      op(EMB_CYC_XWR_IDX, 16'h660F, 0, 0, 0, 1, 0);
      @(posedge clk) prog_mode <= 1'b1;
      op(EMB_CYC_XRD_WIDE, 16'h3C5A, 0, 1, 0, 0, 1);
      op(EMB_CYC_XWR_WIDE, 16'h2001, 0, 0, 0, 0, 0);
      @(posedge clk) bit_en <= 1'b1;
      op(EMB_CYC_XWR_WIDE, 16'h2002, 0, 0, 0, 1, 0);
      @(posedge clk) pin <= 1'b0;
      repeat (6) @(posedge clk);
      op(EMB_CYC_XWR_WIDE, 16'h2003, 0, 0, 0, 0, 0);
      chk(8'(allow), 8'h00);
      @(posedge clk);
      rst_n <= 1'b0;
      sel <= 1'b1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      #1 chk(8'(fx), 8'h00);
      complete_run();
   end
endmodule
bind emb_ctrl emb_ctrl_props u_props (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
   .high_address_port_latch(high_address_port_latch), .ext_prog_mode(ext_prog_mode),
   .high_address_lines(high_address_lines), .muxed_addr_data_out(muxed_addr_data_out),
   .muxed_addr_data_oe(muxed_addr_data_oe), .program_store_strobe_n(program_store_strobe_n),
   .addr_latch_strobe(addr_latch_strobe), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
   .fetch_external(fetch_external), .flash_prog_allowed(flash_prog_allowed));
